// ==== bsp_pkg.sv ====
/*
 Shared constants of the bus slave port: tag encodings, control register map,
 field positions, reset values and the response state type.
 Assumes only a SystemVerilog compiler; imported by every design file except the memory.
*/
package bsp_pkg;
	// Generation defaults for the port widths, then fixed memory, id, counter, AXI address and control widths.
	localparam int DAT_W_DEF = 32;
	localparam int ADR_W_DEF = 32;
	localparam int GRAN_DEF  = 8;
	localparam int TGC_W_DEF = 3;
	localparam int TGA_W_DEF = 2;
	localparam int TGD_W_DEF = 0;
	localparam int MEM_AW    = 8;
	localparam int MID_W     = 2;
	localparam int CNT_W     = 16;
	localparam int AXI_AW    = 5;
	localparam int CTRL_W    = 2;

	// Burst type encodings carried on the address tag.
	localparam logic [1:0] BTE_LINEAR = 2'h0;
	localparam logic [1:0] BTE_WRAP4  = 2'h1;
	localparam logic [1:0] BTE_WRAP8  = 2'h2;

	// Cycle type encodings carried on the cycle tag.
	localparam logic [2:0] CTI_CLASSIC = 3'h0;
	localparam logic [2:0] CTI_CONST   = 3'h1;
	localparam logic [2:0] CTI_INCR    = 3'h2;
	localparam logic [31:0] CTI_END_DEF = 32'h0000_0007;

	// Control register map, byte addresses.
	localparam logic [AXI_AW-1:0] REG_CTRL   = 5'h00;
	localparam logic [AXI_AW-1:0] REG_STATUS = 5'h04;
	localparam logic [AXI_AW-1:0] REG_ACKS   = 5'h08;
	localparam logic [AXI_AW-1:0] REG_ERRS   = 5'h0C;
	localparam logic [AXI_AW-1:0] REG_RTYS   = 5'h10;

	// Field positions and reset values.
	localparam int CTRL_RETRY_BIT = 0;
	localparam int CTRL_WPROT_BIT = 1;
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
	localparam int ST_LOCK_BIT  = 0;
	localparam int ST_OWNER_LSB = 2;
	localparam int ST_CTI_LSB   = 8;
	localparam int ST_BTE_LSB   = 12;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Response state, Gray coded along idle, respond, stream.
	typedef enum logic [1:0] {
		BSP_IDLE   = 2'b00,
		BSP_RESP   = 2'b01,
		BSP_STREAM = 2'b11
	} bsp_state_t;
endpackage : bsp_pkg

// ==== bsp_mem.sv ====
/*
 Word memory behind the slave port, written per granule lane, with a
 registered read port. Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module bsp_mem #(
	parameter int W    = 32,
	parameter int GRAN = 8,
	parameter int AW   = 8
) (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                wr_en,
	input  wire logic [AW-1:0]       wr_addr,
	input  wire logic [W/GRAN-1:0]   wr_lane,
	input  wire logic [W-1:0]        wr_data,
	input  wire logic [AW-1:0]       rd_addr,
	output logic      [W-1:0]        rd_data
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	// Only granules whose select bit is set are stored.
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < W/GRAN; i++) begin
			if (wr_en && wr_lane[i]) begin
				mem[wr_addr][i*GRAN +: GRAN] <= wr_data[i*GRAN +: GRAN];
			end
		end
	end

	// Read data comes out of a register, one edge after the address.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : bsp_mem

// ==== bsp_burst.sv ====
/*
 Burst address step: from the current word address and the burst and cycle
 tags it gives the next beat's word and whether the burst goes on.
 Assumes tags already normalised to three and two bits.
*/
`timescale 1ns/1ps
module bsp_burst #(
	parameter int WAW = 8
) (
	input  wire logic [WAW-1:0] word,
	input  wire logic [1:0]     bte,
	input  wire logic [2:0]     cti,
	input  wire logic           end_hit,
	output logic      [WAW-1:0] nxt_word,
	output logic                cont
);
	import bsp_pkg::*;
	logic [WAW-1:0] mask;
	logic [WAW-1:0] inc;

	// Wrapping bursts only step the low bits, so the beat stays in its block.
	always_comb begin
		case (bte)
			BTE_WRAP4: mask = WAW'(3);    // RULE13
			BTE_WRAP8: mask = WAW'(7);    // RULE13
			default:   mask = '1;
		endcase
		inc = word + WAW'(1);
		if (cti == CTI_CONST) begin
			nxt_word = word;    // RULE14
		end else begin
			nxt_word = (word & ~mask) | (inc & mask);
		end
		cont = ((cti == CTI_CONST) || (cti == CTI_INCR)) && !end_hit;    // RULE14
	end
endmodule : bsp_burst

// ==== bsp_port.sv ====
/*
 Slave port of a shared bus or crossbar interconnect: it ends every strobed
 transfer with acknowledge, error or retry, decodes burst and cycle tags,
 honours the lock, stores data in a local memory and exposes control and
 counters over AXI4-Lite.
 Assumes one clock, synchronous inputs, a synchronous active high reset and
 a master that keeps the bus protocol.

// Overview of operation
// RULE1 - Acknowledge ends a normal cycle and marks a successful transfer.
// RULE2 - Master holds cycle high from first to last transfer of a cycle.
// RULE3 - Error instead of acknowledge signals abnormal termination.
// RULE4 - Retry tells the master the port cannot take or give data now.
// RULE5 - Lock gives one master sole access until lock or cycle falls.
// RULE6 - Every strobe gets exactly one of acknowledge, error, retry.
// RULE7 - Master drives write enable low to read, high to write.
// RULE8 - One select bit per granule of the data port.
// RULE9 - Select marks lanes to store on writes and drive on reads.
// RULE10 - Binary address, low index set by port size, top chosen per core.
// RULE11 - Address tag is valid only while strobe is high.
// RULE12 - Cycle tag is valid only while cycle is high; tells cycle kinds apart.
// RULE13 - Burst tag: 00 linear, 01 wrap four, 10 wrap eight.
// RULE14 - Cycle tag: 000 classic, 001 constant, 010 incrementing, 111 end.
// RULE15 - Cycle, address, data tag widths default 3, 2, 0; zero removes tag.
// RULE16 - End of burst pattern is a parameter, default 111, compared against.
// RULE17 - Data width 8, 16, 32 or 64, default 32; address width default 32.
// RULE18 - Granularity 8, 16, 32 or 64, default 8, sets select coverage.
// RULE19 - A slave may use a data interface narrower than the bus.
// RULE20 - Master decides its reaction to error and its retry timing.
// RULE21 - Outputs registered on the rising clock edge; inputs stable before it.
// RULE22 - Reset restarts the interface and returns state machines to idle.
// RULE23 - At most one response at a time, none without cycle and strobe.
*/
`timescale 1ns/1ps
module bsp_port #(
	parameter int          DAT_W   = bsp_pkg::DAT_W_DEF, // RULE17
	parameter int          ADR_W   = bsp_pkg::ADR_W_DEF,
	parameter int          GRAN    = bsp_pkg::GRAN_DEF, // RULE18
	parameter int          SLV_W   = bsp_pkg::DAT_W_DEF,
	parameter int          TGC_W   = bsp_pkg::TGC_W_DEF,
	parameter int          TGA_W   = bsp_pkg::TGA_W_DEF,
	parameter int          TGD_W   = bsp_pkg::TGD_W_DEF,
	parameter logic [31:0] END_TAG = bsp_pkg::CTI_END_DEF,
	localparam int         TGC_PW  = (TGC_W > 0) ? TGC_W : 1,
	localparam int         TGA_PW  = (TGA_W > 0) ? TGA_W : 1,
	localparam int         TGD_PW  = (TGD_W > 0) ? TGD_W : 1
) (
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire logic                        cyc,
	input  wire logic                        stb,
	input  wire logic                        lock,
	input  wire logic                        we,
	input  wire logic [DAT_W/GRAN-1:0]       sel, // RULE8
	input  wire logic [ADR_W-1:0]            adr,
	input  wire logic [TGA_PW-1:0]           tga,
	input  wire logic [TGC_PW-1:0]           tgc,
	input  wire logic [bsp_pkg::MID_W-1:0]   mst_id,
	input  wire logic [DAT_W-1:0]            wr_dat,
	input  wire logic [TGD_PW-1:0]           wr_tgd,
	output logic      [DAT_W-1:0]            rd_dat,
	output logic      [TGD_PW-1:0]           rd_tgd,
	output logic                             ack,
	output logic                             err,
	output logic                             rty,
	input  wire logic [bsp_pkg::AXI_AW-1:0]  awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic      [1:0]                  bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [bsp_pkg::AXI_AW-1:0]  araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic      [31:0]                 rdata,
	output logic      [1:0]                  rresp,
	output logic                             rvalid,
	input  wire logic                        rready
);
	import bsp_pkg::*;

	localparam int AB = $clog2(DAT_W/8);    // Byte offset bits below the word.
	localparam int SLV_SEL = SLV_W/GRAN;

	bsp_state_t          state;
	bsp_state_t          next_state;
	logic                next_ack;
	logic                next_err;
	logic                next_rty;
	logic [2:0]          cti3;
	logic [1:0]          bte2;
	logic                end_hit;
	logic [MEM_AW-1:0]   word;
	logic [MEM_AW-1:0]   nxt_word;
	logic                cont;
	logic                burst_go;
	logic                range_bad;
	logic                lock_held;
	logic [MID_W-1:0]    owner;
	logic                lock_other;
	logic [2:0]          cti_q;
	logic [1:0]          bte_q;
	logic [CTRL_W-1:0]   ctrl;
	logic [CNT_W-1:0]    cnt_ack;
	logic [CNT_W-1:0]    cnt_err;
	logic [CNT_W-1:0]    cnt_rty;
	logic [SLV_W-1:0]    mem_rd;
	logic                aw_have;
	logic                w_have;
	logic [AXI_AW-1:0]   aw_q;
	logic [31:0]         wd_q;
	logic [3:0]          ws_q;
	logic                wr_do;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// Counter step; a software clear in the same cycle as a hardware event restarts the count at one.
	function automatic logic [CNT_W-1:0] cnt_next(logic [CNT_W-1:0] c, logic inc,
		logic clr);
		logic [CNT_W-1:0] base;
		base = clr ? '0 : c;
		return inc ? base + CNT_W'(1) : base;
	endfunction : cnt_next

	// Known register offsets; anything else answers with a decode error.
	function automatic logic reg_hit(logic [AXI_AW-1:0] a);
		return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_ACKS) ||
			(a == REG_ERRS) || (a == REG_RTYS);
	endfunction : reg_hit

	// Tags narrower than their codes, or absent, read as classic and linear.
	generate
		if (TGC_W >= 3) begin : g_cti
			assign cti3 = tgc[2:0];    // RULE12
		end else begin : g_nocti
			assign cti3 = CTI_CLASSIC;    // RULE15
		end
		if (TGC_W > 0) begin : g_end
			assign end_hit = (tgc == END_TAG[TGC_PW-1:0]);    // RULE16
		end else begin : g_noend
			assign end_hit = 1'b0;    // RULE15
		end
		if (TGA_W >= 2) begin : g_bte
			assign bte2 = tga[1:0];    // RULE11
		end else begin : g_nobte
			assign bte2 = BTE_LINEAR;    // RULE15
		end
	endgenerate

	// Word index sits above the byte offset; higher set bits miss the memory.
	assign word = adr[AB +: MEM_AW];    // RULE10
	assign range_bad = |(adr >> (AB + MEM_AW));    // RULE10
	assign lock_other = lock_held && (mst_id != owner);    // RULE5
	assign burst_go = (state == BSP_STREAM) && cont;

	bsp_burst #(
		.WAW      (MEM_AW)
	) u_burst (
		.word     (word),
		.bte      (bte2),
		.cti      (cti3),
		.end_hit  (end_hit),
		.nxt_word (nxt_word),
		.cont     (cont)
	);

	// A streaming beat prefetches the next word so bursts run without waits.
	bsp_mem #(
		.W        (SLV_W),
		.GRAN     (GRAN),
		.AW       (MEM_AW)
	) u_mem (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (ack && cyc && stb && we),    // RULE7
		.wr_addr  (word),
		.wr_lane  (sel[SLV_SEL-1:0]),    // RULE9
		.wr_data  (wr_dat[SLV_W-1:0]),
		.rd_addr  (burst_go ? nxt_word : word),
		.rd_data  (mem_rd)
	);

	// Lanes above a narrow slave read as zero.
	generate
		if (SLV_W < DAT_W) begin : g_narrow
			assign rd_dat = {{(DAT_W-SLV_W){1'b0}}, mem_rd};    // RULE19
		end else begin : g_full
			assign rd_dat = mem_rd;    // RULE9
		end
	endgenerate

	// One decision per strobe; retry outranks error, which outranks acknowledge.
	always_comb begin
		next_ack = 1'b0;
		next_err = 1'b0;
		next_rty = 1'b0;
		next_state = BSP_IDLE;
		if (cyc && stb && ((state == BSP_IDLE) || burst_go)) begin    // RULE23
			if (ctrl[CTRL_RETRY_BIT] || lock_other) begin
				next_rty = 1'b1;    // RULE4
			end else if (range_bad || (we && ctrl[CTRL_WPROT_BIT])) begin
				next_err = 1'b1;    // RULE3
			end else begin
				next_ack = 1'b1;    // RULE1
			end
			next_state = (next_ack && cont) ? BSP_STREAM : BSP_RESP;    // RULE6
		end
	end

	// Responses leave from flip-flops; reset drops them and idles the port.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= BSP_IDLE;    // RULE22
			ack <= 1'b0;
			err <= 1'b0;
			rty <= 1'b0;
		end else begin
			state <= next_state;
			ack <= next_ack;    // RULE21
			err <= next_err;
			rty <= next_rty;
		end
	end

	// Ownership ends when the cycle drops or the owner releases the lock.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lock_held <= 1'b0;
			owner <= '0;
		end else if (lock_held) begin
			if (!cyc || ((mst_id == owner) && !lock)) begin
				lock_held <= 1'b0;    // RULE5
			end
		end else if (cyc && stb && lock && (state == BSP_IDLE) &&
			!ctrl[CTRL_RETRY_BIT]) begin
			lock_held <= 1'b1;    // RULE5
			owner <= mst_id;
		end
	end

	// Tags are sampled only while their qualifier is high.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cti_q <= CTI_CLASSIC;
			bte_q <= BTE_LINEAR;
		end else begin
			if (cyc) begin
				cti_q <= cti3;    // RULE12
			end
			if (cyc && stb) begin
				bte_q <= bte2;    // RULE11
			end
		end
	end

	// Data tag follows the last stored beat; it stays zero when absent.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_tgd <= '0;
		end else if (ack && cyc && stb && we && (TGD_W > 0)) begin
			rd_tgd <= wr_tgd;    // RULE15
		end
	end

	// Response counters, cleared by any write to their offset.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_ack <= '0;
			cnt_err <= '0;
			cnt_rty <= '0;
		end else begin
			cnt_ack <= cnt_next(cnt_ack, ack, wr_do && (aw_q == REG_ACKS));
			cnt_err <= cnt_next(cnt_err, err, wr_do && (aw_q == REG_ERRS));
			cnt_rty <= cnt_next(cnt_rty, rty, wr_do && (aw_q == REG_RTYS));
		end
	end

	// Write address and data are taken in either order, then answered once.
	assign wr_do = aw_have && w_have && !bvalid;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			awready <= !(awvalid && awready) && !aw_have && !bvalid;
			wready <= !(wvalid && wready) && !w_have && !bvalid;
			if (awvalid && awready) begin
				aw_have <= 1'b1;
				aw_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_have <= 1'b1;
				wd_q <= wdata;
				ws_q <= wstrb;
			end
			if (wr_do) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				bvalid <= 1'b1;
				bresp <= reg_hit(aw_q) ? RESP_OKAY : RESP_DECERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Control bits steer the responder: forced retry and write protection.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl <= CTRL_RST;
		end else if (wr_do && (aw_q == REG_CTRL) && ws_q[0]) begin
			ctrl <= wd_q[CTRL_W-1:0];
		end
	end

	// Reads answer one edge after the address is taken; gaps read as zero.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= reg_hit(araddr) ? RESP_OKAY : RESP_DECERR;
			rdata <= '0;
			case (araddr)
				REG_CTRL:   rdata[CTRL_W-1:0] <= ctrl;
				REG_STATUS: begin
					rdata[ST_LOCK_BIT] <= lock_held;
					rdata[ST_OWNER_LSB +: MID_W] <= owner;
					rdata[ST_CTI_LSB +: 3] <= cti_q;
					rdata[ST_BTE_LSB +: 2] <= bte_q;
				end
				REG_ACKS:   rdata[CNT_W-1:0] <= cnt_ack;
				REG_ERRS:   rdata[CNT_W-1:0] <= cnt_err;
				REG_RTYS:   rdata[CNT_W-1:0] <= cnt_rty;
				default:    rdata <= '0;
			endcase
		end else if (rvalid) begin
			if (rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end else begin
			arready <= 1'b1;
		end
	end

	// Checks on the responder, lock and burst stepping.
	property p_onehot;
		$onehot0({ack, err, rty});
	endproperty
	a_onehot: assert property (p_onehot) else $error("two responses at once"); // RULE23

	property p_qual;
		(ack || err || rty) |-> $past(cyc && stb);
	endproperty
	a_qual: assert property (p_qual) else $error("response without strobe"); // RULE23

	property p_answer;
		(cyc && stb && state == BSP_IDLE) |=> $onehot({ack, err, rty});
	endproperty
	a_answer: assert property (p_answer) else $error("strobe not answered"); // RULE6

	property p_no_double;
		(state == BSP_RESP) |-> ##1 !(ack || err || rty);
	endproperty
	a_no_double: assert property (p_no_double) else $error("strobe answered twice"); // RULE6

	property p_retry;
		(cyc && stb && state == BSP_IDLE && ctrl[CTRL_RETRY_BIT]) |=> rty && !ack;
	endproperty
	a_retry: assert property (p_retry) else $error("forced retry missing"); // RULE4

	property p_err;
		(cyc && stb && we && state == BSP_IDLE && ctrl == 2'h2 && !lock_other)
			|=> err;
	endproperty
	a_err: assert property (p_err) else $error("protected write not refused"); // RULE3

	property p_lock_block;
		(lock_other && cyc && stb && state == BSP_IDLE) |=> rty;
	endproperty
	a_lock_block: assert property (p_lock_block) else $error("locked port let in"); // RULE5

	property p_lock_end;
		(lock_held && !cyc) |=> !lock_held;
	endproperty
	a_lock_end: assert property (p_lock_end) else $error("lock kept past cycle"); // RULE5

	property p_end_burst;
		(ack && cyc && stb && end_hit) |=> !(ack || err || rty);
	endproperty
	a_end_burst: assert property (p_end_burst) else $error("burst ran past end"); // RULE16

	property p_wrap4;
		(burst_go && bte2 == BTE_WRAP4) |-> (nxt_word[MEM_AW-1:2] == word[MEM_AW-1:2]);
	endproperty
	a_wrap4: assert property (p_wrap4) else $error("wrap four left its block"); // RULE13

	c_read: cover property (cyc && stb && !we ##1 ack);
	c_stream: cover property (ack && state == BSP_STREAM ##1 ack);
	c_retry: cover property (rty);
	c_error: cover property (err);
endmodule : bsp_port

// ==== bsp_master_model.sv ====
/*
 Bus master model driving the slave port: single beats and bursts on request.
 Assumes one clock, a synchronous active high reset and a bench that waits
 for done before it asks again.
*/
`timescale 1ns/1ps
module bsp_master_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic [31:0] go_adr,
	input  wire logic [31:0] go_dat,
	input  wire logic [20:0] go_f,
	input  wire logic        ack,
	input  wire logic        err,
	input  wire logic        rty,
	output logic             cyc,
	output logic             stb,
	output logic             lock,
	output logic             we,
	output logic      [3:0]  sel,
	output logic      [31:0] adr,
	output logic      [1:0]  tga,
	output logic      [2:0]  tgc,
	output logic      [1:0]  mst_id,
	output logic      [31:0] wr_dat,
	output logic             done
);
	import bsp_pkg::*;
	logic       busy;
	logic       keep;
	logic [3:0] cnt;
	logic [2:0] wt;

	// Beat sequencer; released address, data, select and address tag lines toggle, and the cycle tag once cycle drops, so a stale value never passes for a live one.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{busy, keep, cyc, stb, lock, we, done} <= '0;
			{cnt, wt, sel, tga, tgc, mst_id} <= '0;
			{adr, wr_dat} <= '0;
		end else begin
			done <= 1'b0;
			if (!busy && go) begin
				{we, lock, keep, mst_id, tga, tgc, cnt, wt, sel} <= go_f;
				{busy, cyc} <= 2'b11;
				stb <= (go_f[6:4] == 3'h0);
				adr <= go_adr;
				wr_dat <= go_dat;
			end else if (stb && (ack || err || rty)) begin
				if (ack && cnt > 4'h1) begin
					cnt <= cnt - 4'h1;
					wr_dat <= wr_dat + 32'h0000_0001;
					if (cnt == 4'h2)
						tgc <= CTI_END_DEF[2:0];
					if (tgc != CTI_CONST) begin
						if (tga == BTE_WRAP4)
							adr[3:2] <= adr[3:2] + 2'h1;
						else if (tga == BTE_WRAP8)
							adr[4:2] <= adr[4:2] + 3'h1;
						else
							adr[9:2] <= adr[9:2] + 8'h01;
					end
				end else begin
					// Error, retry or the last acknowledge ends the burst; when to try again is left to the bench.
					{busy, stb, done} <= 3'b001;
					if (!keep)
						{cyc, lock} <= 2'b00;
				end
			end else if (busy && !stb) begin
				wt <= wt - 3'h1;
				if (wt == 3'h1)
					stb <= 1'b1;
			end else if (!busy) begin
				adr <= ~adr;
				wr_dat <= ~wr_dat;
				sel <= ~sel;
				tga <= ~tga;
				if (!cyc)
					tgc <= ~tgc;
			end
		end
	end
endmodule : bsp_master_model

// ==== testbench.sv ====
/*
 Self-checking bench of the slave port: random singles, bursts, faults, lock,
 control and counters over AXI4-Lite, and a reset in mid run.
 Assumes the port at default widths with the master model beside it.
*/
`timescale 1ns/1ps
module testbench;
	import bsp_pkg::*;
	localparam int LIMIT = 30000;
	localparam logic [9:0] SW = {3'b100, 2'h0, BTE_LINEAR, CTI_CLASSIC};
	localparam logic [9:0] SR = {3'b000, 2'h0, BTE_LINEAR, CTI_CLASSIC};
	localparam logic [7:0] BB [4] = '{8'h0a, 8'h06, 8'h0d, 8'h0b};
	localparam logic [1:0] BT [4] = '{BTE_LINEAR, BTE_WRAP4, BTE_WRAP8, BTE_LINEAR};
	localparam logic [2:0] CT [4] = '{CTI_INCR, CTI_INCR, CTI_INCR, CTI_CONST};
	localparam logic [3:0] NN [4] = '{4'h4, 4'h4, 4'h5, 4'h3};
	logic        core_clk, rst, go, cyc, stb, lock, we, ack, err, rty, done, tgd;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0]  sel, wstrb;
	logic [31:0] go_adr, go_dat, adr, wr_dat, rd_dat, wdata, rdata, v, m, mem [256];
	logic [31:0] dq [$];
	logic [20:0] go_f;
	logic [1:0]  tga, mst_id, bresp, rresp, r, kq [$];
	logic [2:0]  tgc;
	logic [4:0]  awaddr, araddr;
	int          mismatches = 0, checked = 0, cycles = 0, wd, ws, i, j;

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	bsp_port bsp_port_inst (.core_clk(core_clk), .rst(rst), .cyc(cyc), .stb(stb), .lock(lock),
		.we(we), .sel(sel), .adr(adr), .tga(tga), .tgc(tgc), .mst_id(mst_id), .wr_dat(wr_dat),
		.wr_tgd(1'b0), .rd_dat(rd_dat), .rd_tgd(tgd), .ack(ack), .err(err), .rty(rty),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	bsp_master_model bsp_master_model_inst (.core_clk(core_clk), .rst(rst), .go(go),
		.go_adr(go_adr), .go_dat(go_dat), .go_f(go_f), .ack(ack), .err(err), .rty(rty),
		.cyc(cyc), .stb(stb), .lock(lock), .we(we), .sel(sel), .adr(adr), .tga(tga), .tgc(tgc),
		.mst_id(mst_id), .wr_dat(wr_dat), .done(done));

	// Log every response with its read data; error and retry at once give an illegal kind.
	always @(posedge core_clk) begin
		if (cyc && (ack || err || rty)) begin
			kq.push_back({rty, err});
			dq.push_back(rd_dat);
		end
	end

	// Cut a hang short and close the run.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (exp !== got) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic logic [31:0] lanes(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lanes

	// Expected word of beat j, worked out from the start word and the tags.
	function automatic logic [7:0] ew(input logic [7:0] b, input logic [1:0] bt,
			input logic [2:0] ct, input int j);
		if (ct == CTI_CONST)
			return b;
		if (bt == BTE_WRAP4)
			return {b[7:2], 2'(b[1:0] + j)};
		if (bt == BTE_WRAP8)
			return {b[7:3], 3'(b[2:0] + j)};
		return 8'(b + j);
	endfunction : ew

	// One request to the master model; every beat must end with the expected kind.
	task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic [9:0] hi,
			input logic [3:0] n, input logic [3:0] s, input logic [1:0] ek);
		int k;
		kq.delete();
		dq.delete();
		@(posedge core_clk);
		go_adr <= a;
		go_dat <= d;
		go_f <= {hi, n, 3'($urandom_range(0, 3)), s};
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 200) begin
			@(posedge core_clk);
			k++;
		end
		@(negedge core_clk);
		check("beat count", 32'(n), 32'(kq.size()));
		foreach (kq[q])
			check("response kind", 32'(ek), 32'(kq[q]));
	endtask : xfer

	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rs);
		int k;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		{awvalid, wvalid, bready} <= 3'b111;
		k = 0;
		do begin
			@(posedge core_clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			k++;
		end while (bvalid !== 1'b1 && k < 200);
		if (bvalid !== 1'b1)
			mismatches++;
		rs = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [4:0] a, output logic [31:0] dv, output logic [1:0] rs);
		int k;
		@(posedge core_clk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		k = 0;
		do begin
			@(posedge core_clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			k++;
		end while (rvalid !== 1'b1 && k < 200);
		if (rvalid !== 1'b1)
			mismatches++;
		dv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Main sequence: reset, fill, random traffic, then the corner cases.
	initial begin
		{rst, go, go_adr, go_dat, go_f} = {1'b1, 86'h0};
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		void'($urandom(32'h6f9b));
		axi_rd(REG_CTRL, v, r);
		check("ctrl after reset", 32'h0000_0000, v);
		axi_rd(5'h14, v, r);
		check("unmapped read resp", 32'(RESP_DECERR), 32'(r));
		for (i = 0; i < 256; i++) begin
			mem[i] = $urandom;
			xfer(32'(i * 4), mem[i], SW, 4'h1, 4'hf, 2'h0);
		end
		for (i = 0; i < 60; i++) begin
			wd = $urandom_range(0, 255);
			ws = $urandom_range(0, 15);
			v = $urandom;
			m = lanes(4'(ws));
			if ($urandom_range(0, 1) == 1) begin
				xfer(32'(wd * 4), v, SW, 4'h1, 4'(ws), 2'h0);
				mem[wd] = (mem[wd] & ~m) | (v & m);
			end else begin
				xfer(32'(wd * 4), v, SR, 4'h1, 4'(ws), 2'h0);
				check("read lanes", mem[wd] & m, dq[0] & m);
			end
		end
		xfer(32'h0000_0028, 32'ha000_0000, {3'b100, 2'h0, BTE_LINEAR, CTI_INCR}, 4'h3, 4'hf,
			2'h0);
		for (j = 0; j < 3; j++)
			mem[10 + j] = 32'ha000_0000 + 32'(j);
		for (i = 0; i < 4; i++) begin
			xfer(32'(BB[i]) << 2, 32'h0, {3'b000, 2'h0, BT[i], CT[i]}, NN[i], 4'hf, 2'h0);
			for (j = 0; j < NN[i]; j++)
				check("burst data", mem[ew(BB[i], BT[i], CT[i], j)], dq[j]);
		end
		xfer(32'h0001_0014, 32'h5a5a_5a5a, SW, 4'h1, 4'hf, 2'h1);
		xfer(32'h0000_0014, 32'h0, SR, 4'h1, 4'hf, 2'h0);
		check("rejected write kept", mem[5], dq[0]);
		axi_wr(REG_CTRL, 32'h0000_0001, r);
		xfer(32'h0, 32'h0, SR, 4'h1, 4'hf, 2'h2);
		axi_wr(REG_CTRL, 32'h0000_0002, r);
		xfer(32'h4, 32'h0, SW, 4'h1, 4'hf, 2'h1);
		xfer(32'h4, 32'h0, SR, 4'h1, 4'hf, 2'h0);
		check("protected word", mem[1], dq[0]);
		axi_wr(REG_CTRL, 32'h0000_0000, r);
		xfer(32'h8, 32'h0, {3'b011, 2'h1, BTE_WRAP4, CTI_CLASSIC}, 4'h1, 4'hf, 2'h0);
		axi_rd(REG_STATUS, v, r);
		check("lock status", 32'h0000_1005, v & 32'h0000_370d);
		xfer(32'h8, 32'h0, {3'b001, 2'h2, BTE_LINEAR, CTI_CLASSIC}, 4'h1, 4'hf, 2'h2);
		xfer(32'h8, 32'h0, {3'b000, 2'h1, BTE_LINEAR, CTI_CLASSIC}, 4'h1, 4'hf, 2'h0);
		xfer(32'h8, 32'h0, {3'b010, 2'h1, BTE_LINEAR, CTI_CLASSIC}, 4'h1, 4'hf, 2'h0);
		xfer(32'h8, 32'h0, {3'b000, 2'h2, BTE_LINEAR, CTI_CLASSIC}, 4'h1, 4'hf, 2'h0);
		axi_wr(REG_ACKS, 32'h0000_0000, r);
		for (i = 0; i < 3; i++)
			xfer(32'h0, 32'h0, SR, 4'h1, 4'hf, 2'h0);
		axi_rd(REG_ACKS, v, r);
		check("ack count", 32'h0000_0003, v);
		axi_wr(5'h1c, 32'h0000_0000, r);
		check("unmapped write resp", 32'(RESP_DECERR), 32'(r));
		axi_wr(REG_CTRL, 32'h0000_0001, r);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		axi_rd(REG_CTRL, v, r);
		check("ctrl after second reset", 32'h0000_0000, v);
		xfer(32'h0, 32'h0, SR, 4'h1, 4'hf, 2'h0);
		check("data tag", 32'h0, 32'(tgd));
		print_verdict();
	end
endmodule : testbench
